// ### adcacc_top.v
// Purpose: Converter configuration, sequencing and result accumulation
// Assumes: Analog core returns a 12-bit code on CORE_DATA with CORE_VALID
// Notes: Registers are reached over the SFR port; no other bus
`timescale 1ns/1ps
`include "adcacc_defs.vh"
module adcacc_top (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire HF_OSC,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_WE,
  input wire SFR_RE,
  output reg [7:0] SFR_RDATA,
  input wire CONV_START,
  input wire [11:0] CORE_DATA,
  input wire CORE_VALID,
  output reg CORE_SAMPLE,
  output reg CM_BUFFER_ON,
  output reg PGA_GAIN_SEL,
  output reg [1:0] RESOLUTION,
  output reg CONV_DONE_FLAG
);
  localparam ST_IDLE = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV = 2'h2;

  reg [7:0] adc_accumulate_config;
  reg [7:0] adc_clock_mode_config;
  reg cm_buffer_on;
  reg adc_enable;
  reg burst_sel;
  reg conv_done_flag;
  reg start_meta;
  reg start_sync;
  reg start_prev;
  reg [1:0] state;
  reg [5:0] sar_cnt;
  reg [6:0] conv_left;
  reg [17:0] result_word;
  reg busy;
  reg [7:0] next_rdata;
  wire sar_tick;
  wire start_evt;
  wire [4:0] sar_clk_divider;
  wire eight_bit_sel;
  wire delayed_track_sel;
  wire pga_gain_sel;
  wire twelve_bit_sel;
  wire accumulate_on;
  wire [2:0] shift_justify_sel;
  wire [2:0] repeat_count;
  wire [15:0] formatted;
  wire [11:0] core_code;
  wire [5:0] conv_len;

  assign sar_clk_divider = adc_clock_mode_config[7:3];
  assign eight_bit_sel = adc_clock_mode_config[`ADCACC_CF_EIGHT];
  assign delayed_track_sel = adc_clock_mode_config[`ADCACC_CF_DTRACK];
  assign pga_gain_sel = adc_clock_mode_config[`ADCACC_CF_GAIN];
  assign twelve_bit_sel = adc_accumulate_config[`ADCACC_AC_TWELVE];
  assign accumulate_on = adc_accumulate_config[`ADCACC_AC_ACCUM];
  assign shift_justify_sel = adc_accumulate_config[5:3];
  assign repeat_count = adc_accumulate_config[2:0];
  assign start_evt = adc_enable & start_sync & ~start_prev;

  // Conversions per burst for a repeat code
  function [6:0] burst_count;
    input [2:0] code;
    input twelve;
    reg [6:0] base;
    begin
      case (code)
        3'h0: base = 7'h01;
        3'h1: base = 7'h04;
        3'h2: base = 7'h08;
        3'h3: base = 7'h10;
        3'h4: base = 7'h20;
        3'h5: base = 7'h40;
        default: base = 7'h01;
      endcase
      if (twelve && code != 3'h0)
        burst_count = base >> 2;
      else
        burst_count = base;
    end
  endfunction

  // Right-aligns the top bits of the core code for the active resolution
  assign core_code = eight_bit_sel ? {4'h0, CORE_DATA[11:4]} :
                     twelve_bit_sel ? CORE_DATA :
                     {2'h0, CORE_DATA[11:2]};
  // Twelve-bit conversions take 59 SAR clocks instead of 14
  assign conv_len = twelve_bit_sel ? `ADCACC_CONV12_SAR_CYCLES : `ADCACC_CONV_SAR_CYCLES;

  assign formatted = (shift_justify_sel == 3'h4) ?
                     (eight_bit_sel ? {result_word[7:0], 8'h00} :
                      twelve_bit_sel ? {result_word[11:0], 4'h0} :
                      {result_word[9:0], 6'h00}) :
                     (shift_justify_sel[2] ? 16'h0000 :
                      result_word[15:0] >> shift_justify_sel[1:0]);

  adcacc_clkdiv u_clkdiv (
    .SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N),
    .burst_sel(burst_sel),
    .hf_osc(HF_OSC),
    .sar_clk_divider(sar_clk_divider),
    .sar_tick(sar_tick)
  );

  always @* begin
    next_rdata = 8'h00;
    case (SFR_ADDR)
      `ADCACC_ADDR_ACCUM: next_rdata = adc_accumulate_config;
      `ADCACC_ADDR_CLKMODE: next_rdata = adc_clock_mode_config;
      `ADCACC_ADDR_BUFCTL: next_rdata = {7'h00, cm_buffer_on};
      `ADCACC_ADDR_CTRL0: next_rdata = {adc_enable, burst_sel, conv_done_flag, busy, 4'h0};
      `ADCACC_ADDR_RES_HI: next_rdata = formatted[15:8];
      `ADCACC_ADDR_RES_LO: next_rdata = formatted[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      adc_accumulate_config <= `ADCACC_RST_ACCUM;
      adc_clock_mode_config <= `ADCACC_RST_CLKMODE;
      cm_buffer_on <= 1'b0;
      adc_enable <= 1'b0;
      burst_sel <= 1'b0;
      conv_done_flag <= 1'b0;
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_prev <= 1'b0;
      state <= ST_IDLE;
      sar_cnt <= 6'h00;
      conv_left <= 7'h00;
      result_word <= 18'h00000;
      busy <= 1'b0;
      SFR_RDATA <= 8'h00;
      CORE_SAMPLE <= 1'b0;
      CM_BUFFER_ON <= 1'b0;
      PGA_GAIN_SEL <= 1'b0;
      RESOLUTION <= 2'h1;
      CONV_DONE_FLAG <= 1'b0;
    end else begin
      start_meta <= CONV_START;
      start_sync <= start_meta;
      start_prev <= start_sync;
      CORE_SAMPLE <= 1'b0;
      if (SFR_RE)
        SFR_RDATA <= next_rdata;
      if (SFR_WE) begin
        case (SFR_ADDR)
          `ADCACC_ADDR_ACCUM: adc_accumulate_config <= SFR_WDATA;
          `ADCACC_ADDR_CLKMODE: adc_clock_mode_config <= SFR_WDATA;
          `ADCACC_ADDR_BUFCTL: cm_buffer_on <= SFR_WDATA[0];
          `ADCACC_ADDR_CTRL0: begin
            adc_enable <= SFR_WDATA[`ADCACC_CTRL0_ENABLE];
            burst_sel <= SFR_WDATA[`ADCACC_CTRL0_BURST];
            if (!SFR_WDATA[`ADCACC_CTRL0_DONE])
              conv_done_flag <= 1'b0;
          end
          // Writing either half with zero clears the sum
          `ADCACC_ADDR_RES_HI, `ADCACC_ADDR_RES_LO: begin
            if (SFR_WDATA == 8'h00)
              result_word <= 18'h00000;
          end
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: begin
          busy <= 1'b0;
          if (start_evt) begin
            busy <= 1'b1;
            sar_cnt <= 6'h00;
            conv_left <= burst_sel ? burst_count(repeat_count, twelve_bit_sel) : 7'h01;
            if (burst_sel)
              result_word <= 18'h00000;
            state <= delayed_track_sel ? ST_TRACK : ST_CONV;
          end
        end
        ST_TRACK: begin
          if (sar_tick) begin
            sar_cnt <= sar_cnt + 6'h01;
            if (sar_cnt == {3'h0, `ADCACC_DELAY_SAR_CYCLES} - 6'h01) begin
              sar_cnt <= 6'h00;
              state <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (sar_tick && sar_cnt != conv_len)
            sar_cnt <= sar_cnt + 6'h01;
          if (sar_tick && sar_cnt == 6'h00)
            CORE_SAMPLE <= 1'b1;
          if (CORE_VALID && sar_cnt == conv_len) begin
            if (burst_sel || accumulate_on)
              result_word <= result_word + {6'h00, core_code};
            else
              result_word <= {6'h00, core_code};
            sar_cnt <= 6'h00;
            conv_left <= conv_left - 7'h01;
            if (conv_left == 7'h01) begin
              conv_done_flag <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      CM_BUFFER_ON <= cm_buffer_on;
      PGA_GAIN_SEL <= pga_gain_sel;
      RESOLUTION <= eight_bit_sel ? 2'h0 : (twelve_bit_sel ? 2'h2 : 2'h1);
      CONV_DONE_FLAG <= conv_done_flag;
    end
  end
endmodule // adcacc_top

// ### adcacc_defs.vh
// Purpose: Constants for the converter configuration and accumulator block
// Assumes: 8-bit special-function register port, one system clock
// Notes: Offsets are byte addresses on the register port
`ifndef ADCACC_DEFS_VH
`define ADCACC_DEFS_VH
`define ADCACC_ADDR_ACCUM 8'hB3
`define ADCACC_ADDR_CLKMODE 8'hBC
`define ADCACC_ADDR_BUFCTL 8'hB2
`define ADCACC_ADDR_CTRL0 8'hE8
`define ADCACC_ADDR_RES_HI 8'hBE
`define ADCACC_ADDR_RES_LO 8'hBD
`define ADCACC_RST_ACCUM 8'h00
`define ADCACC_RST_CLKMODE 8'hF8
`define ADCACC_RST_BUFCTL 8'h00
`define ADCACC_RST_CTRL0 8'h00
`define ADCACC_CTRL0_ENABLE 7
`define ADCACC_CTRL0_BURST 6
`define ADCACC_CTRL0_DONE 5
`define ADCACC_CTRL0_BUSY 4
`define ADCACC_CF_EIGHT 2
`define ADCACC_CF_DTRACK 1
`define ADCACC_CF_GAIN 0
`define ADCACC_AC_TWELVE 7
`define ADCACC_AC_ACCUM 6
`define ADCACC_DELAY_SAR_CYCLES 3'h4
`define ADCACC_CONV_SAR_CYCLES 6'h0E
`define ADCACC_CONV12_SAR_CYCLES 6'h3B
`define ADCACC_TWELVE_FACTOR 3'h4
`endif

// ### adcacc_clkdiv.v
// Purpose: SAR clock tick generator from the selected ADC input clock
// Assumes: High-frequency oscillator arrives as a level, resynchronised here
// Notes: Tick is one system-clock pulse per SAR clock period
`timescale 1ns/1ps
module adcacc_clkdiv (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire burst_sel,
  input wire hf_osc,
  input wire [4:0] sar_clk_divider,
  output reg sar_tick
);
  reg hf_meta;
  reg hf_sync;
  reg hf_prev;
  reg [4:0] div_cnt;
  wire src_tick;

  // Source is system clock or oscillator edges in burst mode
  assign src_tick = burst_sel ? (hf_sync & ~hf_prev) : 1'b1;

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      hf_meta <= 1'b0;
      hf_sync <= 1'b0;
      hf_prev <= 1'b0;
      div_cnt <= 5'h00;
      sar_tick <= 1'b0;
    end else begin
      hf_meta <= hf_osc;
      hf_sync <= hf_meta;
      hf_prev <= hf_sync;
      sar_tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt >= sar_clk_divider) begin
          div_cnt <= 5'h00;
          sar_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 5'h01;
        end
      end
    end
  end
endmodule // adcacc_clkdiv

// ### adcacc_chk.sv
// Purpose: Port checks for the converter configuration block
// Assumes: One SYS_CLK domain, RESET_N synchronous active low
// Notes: Bound to adcacc_top from the bench
`timescale 1ns/1ps
module adcacc_chk (
  input logic SYS_CLK,
  input logic RESET_N,
  input logic [7:0] SFR_ADDR,
  input logic [7:0] SFR_WDATA,
  input logic SFR_WE,
  input logic SFR_RE,
  input logic [7:0] SFR_RDATA,
  input logic CORE_VALID,
  input logic CORE_SAMPLE,
  input logic CM_BUFFER_ON,
  input logic PGA_GAIN_SEL,
  input logic [1:0] RESOLUTION,
  input logic CONV_DONE_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire clr_req = SFR_WE && SFR_ADDR == 8'hE8 && !SFR_WDATA[5];
  wire mapped = SFR_ADDR inside {8'hB2, 8'hB3, 8'hBC, 8'hBD, 8'hBE, 8'hE8};
  // Output copy shows the written bit two edges after the write
  gain_copy_a: assert property (SFR_WE && SFR_ADDR == 8'hBC |->
    ##2 PGA_GAIN_SEL == $past(SFR_WDATA[0], 2))
    else $error("gain output does not follow its bit");
  buf_copy_a: assert property (SFR_WE && SFR_ADDR == 8'hB2 |->
    ##2 CM_BUFFER_ON == $past(SFR_WDATA[0], 2))
    else $error("buffer enable output does not follow its bit");
  res_legal_a: assert property (RESOLUTION != 2'h3)
    else $error("illegal resolution code");
  unmapped_zero_a: assert property (SFR_RE && !mapped |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!SFR_RE |=> $stable(SFR_RDATA))
    else $error("read data changed without a read");
  done_cause_a: assert property ($rose(CONV_DONE_FLAG) |-> $past(CORE_VALID, 2))
    else $error("done rose without a core result");
  done_clear_a: assert property ($fell(CONV_DONE_FLAG) |-> $past(clr_req, 2))
    else $error("done fell without a software clear");
  sample_pulse_a: assert property (CORE_SAMPLE |=> !CORE_SAMPLE)
    else $error("sample pulse longer than one cycle");
  cover property ($rose(CONV_DONE_FLAG));
  cover property ($fell(CONV_DONE_FLAG));
  cover property (CORE_SAMPLE);
endmodule // adcacc_chk

// ### testbench.sv
// Purpose: Self-checking bench for the converter configuration block
// Assumes: SAR divider 0, oscillator toggled every system clock
// Notes: Expected results come from an integer model of the sum
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_n = 0, hf = 0, we = 0, re = 0, start = 0, cvalid = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, b;
  logic [11:0] cdata = 0;
  logic sample, cmb, gain, done;
  logic [1:0] res;
  logic [15:0] got;
  logic [7:0] ra [4] = '{8'hBC, 8'hB3, 8'hB2, 8'h55};
  logic [7:0] rv [4] = '{8'hF8, 8'h00, 8'h00, 8'h00};
  integer fail_count = 0, comparisons = 0, seed = 99, n0, n, i, exp_v, smp = 0, s0v;
  integer acc_q[$];
  always #25 clk = ~clk;
  always @(posedge clk) hf <= ~hf;
  // Counts sampling pulses so burst lengths can be checked
  always @(posedge clk) if (sample === 1'b1) smp <= smp + 1;
  adcacc_top i_dut(.SYS_CLK(clk), .RESET_N(rst_n), .HF_OSC(hf), .SFR_ADDR(addr),
    .SFR_WDATA(wdata), .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata), .CONV_START(start),
    .CORE_DATA(cdata), .CORE_VALID(cvalid), .CORE_SAMPLE(sample), .CM_BUFFER_ON(cmb),
    .PGA_GAIN_SEL(gain), .RESOLUTION(res), .CONV_DONE_FLAG(done));
  task final_report;
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Returns once the registered copies have settled
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; we <= 1;
    @(posedge clk); we <= 0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); addr <= a; re <= 1;
    @(posedge clk); re <= 0;
    @(negedge clk); d = rdata;
  endtask
  task rres(output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(8'hBE, h);
    rd(8'hBD, l);
    v = {h, l};
  endtask
  // Start, wait for done under a bound, then clear the flag
  task conv(input logic [7:0] ctl, output integer c);
    @(posedge clk); cdata <= $random(seed); cvalid <= 1; start <= 1;
    c = 0;
    while (done !== 1'b1 && c < 20000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 20000) begin
      fail_count++;
      final_report;
    end
    start <= 0;
    cvalid <= 0;
    rd(8'hE8, b);
    chk("status", b, ctl | 8'h20);
    wr(8'hE8, ctl);
    chk("done clear", done, 0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 4; i++) begin
      rd(ra[i], b);
      chk("reset value", b, rv[i]);
    end
    chk("resolution", res, 1);
    chk("outputs at reset", {cmb, gain, done, sample}, 0);
    wr(8'hB2, 8'h01);
    wr(8'hBC, 8'h01);
    rd(8'hBC, b);
    chk("clock config", b, 8'h01);
    chk("buffer", cmb, 1);
    chk("gain", gain, 1);
    wr(8'hE8, 8'h80);
    conv(8'h80, n0);
    rres(got);
    chk("single", got, cdata[11:2]);
    wr(8'hBC, 8'h03);
    conv(8'h80, n);
    chk("delayed length", n, n0 + 4);
    wr(8'hBC, 8'h01);
    wr(8'hB3, 8'h80);
    chk("resolution 12", res, 2);
    conv(8'h80, n);
    chk("length 12", n, n0 + 45);
    rres(got);
    chk("result 12", got, cdata);
    wr(8'hBC, 8'h05);
    chk("resolution 8", res, 0);
    conv(8'h80, n);
    rres(got);
    chk("result 8", got, cdata[11:4]);
    wr(8'hBC, 8'h01);
    wr(8'hB3, 8'h48);
    wr(8'hBE, 8'h00);
    for (i = 0; i < 3; i++) begin
      if (i == 2) begin
        wr(8'hBD, 8'h00);
        acc_q.delete();
      end
      conv(8'h80, n);
      acc_q.push_back(cdata[11:2]);
      exp_v = 0;
      foreach (acc_q[k]) exp_v += acc_q[k];
      rres(got);
      chk("accumulate", got, exp_v >> 1);
    end
    wr(8'hB3, 8'h20);
    conv(8'h80, n);
    rres(got);
    chk("left justify", got, {cdata[11:2], 6'h00});
    wr(8'hE8, 8'hC0);
    for (i = 0; i < 6; i++) begin
      wr(8'hB3, i[7:0]);
      s0v = smp;
      conv(8'hC0, n);
      exp_v = (i == 0 ? 1 : 1 << (i + 1));
      chk("burst samples", smp - s0v, exp_v);
      exp_v = exp_v * cdata[11:2];
      rres(got);
      chk("burst sum", got, exp_v[15:0]);
    end
    wr(8'hB3, 8'h81);
    conv(8'hC0, n);
    rres(got);
    chk("burst 12", got, cdata);
    final_report;
  end
endmodule // testbench
bind adcacc_top adcacc_chk i_chk(.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA),
  .CORE_VALID(CORE_VALID), .CORE_SAMPLE(CORE_SAMPLE), .CM_BUFFER_ON(CM_BUFFER_ON),
  .PGA_GAIN_SEL(PGA_GAIN_SEL), .RESOLUTION(RESOLUTION), .CONV_DONE_FLAG(CONV_DONE_FLAG));
